// ===== verilog/mcx_pkg.sv
// Package for the message chain and extension packer.
// Assumes a 32-bit link word; byte n of a word sits at bits 8n+7:8n.
package mcx_pkg;

  typedef enum logic [1:0] {
    MC_REQ  = 2'h0,
    MC_SNP  = 2'h1,
    MC_RSP  = 2'h2,
    MC_MISC = 2'h3
  } mcx_class_t;

  typedef enum logic [2:0] {
    AW_48 = 3'h0,
    AW_52 = 3'h1,
    AW_56 = 3'h2,
    AW_60 = 3'h3,
    AW_64 = 3'h4
  } mcx_awidth_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'h0,
    ST_SEND = 1'h1
  } mcx_state_t;

  // Opcode encodings
  localparam logic [7:0] REQ_CHAIN_CODE      = 8'h3F;
  localparam logic [7:0] SNP_CHAIN_CODE      = 8'h1F;
  localparam logic [7:0] OP_READ_UNCACHED    = 8'h01;
  localparam logic [7:0] OP_WRITE_UNC_PART   = 8'h12;
  localparam logic [7:0] OP_WRITE_COH_PART   = 8'h13;
  localparam logic [7:0] OP_ATOMIC_FIRST     = 8'h20;
  localparam logic [7:0] OP_ATOMIC_LAST      = 8'h2F;

  // Extension byte 0 layout and kinds
  localparam int         EXT_MORE_BIT  = 7;
  localparam int         EXT_KIND_LSB  = 4;
  localparam logic [2:0] KIND_IDS      = 3'h0;
  localparam logic [2:0] KIND_LOWADDR  = 3'h1;
  localparam logic [2:0] KIND_USER     = 3'h2;
  localparam logic [2:0] KIND_ERR      = 3'h6;
  localparam int         EXT_LIMIT     = 8;

  // Header word: byte0 = {ext, 0, class, 0}, byte1 = opcode
  localparam int HDR_EXT_BIT   = 7;
  localparam int HDR_CLASS_LSB = 4;

  // Chain address steps
  localparam logic [63:0] LINE_BYTES_64  = 64'h0000_0000_0000_0040;
  localparam logic [63:0] LINE_BYTES_128 = 64'h0000_0000_0000_0080;

  // Header, extensions, two address words
  localparam int          WORD_SLOTS = 1 + EXT_LIMIT + 2;
  localparam logic [3:0]  CNT_ONE    = 4'h1;

endpackage

// ===== verilog/mcx_packer.sv
// Sender side packer: turns message orders into 32-bit link words,
// chaining Requests and Snoops and appending extension words.
// Assumes the peer's link sink is on sys_clk and gives back-pressure.
`timescale 1ns/100ps

// Function
// - chained Request uses request chain opcode
// - chained Request omits attribute and address words
// - chain address is previous plus line size
// - chain only full aligned line requests
// - chains never cross a packet end
// - chained Request keeps original agent identifiers
// - chain state survives interleaved other messages
// - chained Snoop uses snoop chain opcode
// - chained Snoop copies first broadcast and hint
// - chained Snoop omits address word, line step
// - Snoop chains full line, same packet, interleavable
// - header carries extension follows bit
// - extension word holds more flag, kind
// - extensions follow header in rising kind order
// - at most eight extensions per message
// - kind 000 carries high address and ids
// - kind 001 low address on uncached requests
// - kind 010 user bits, not on misc
// - kind 110 error and poison, data carriers
// - chained message ids equal original's ids
// - line size setting 64 or 128 bytes
// - wide addresses force kind 000 on requests
module mcx_packer #(
  parameter int EXT_SLOTS = mcx_pkg::EXT_LIMIT
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 lineSize128,
  input  wire mcx_pkg::mcx_awidth_t addrWidthSetting,
  input  wire logic                 ordValid,
  output logic                      ordReady,
  input  wire logic                 ordFirst,
  input  wire logic                 ordLast,
  input  wire logic [5:0]           ordPktTgt,
  input  wire logic [5:0]           ordPktSrc,
  input  wire mcx_pkg::mcx_class_t  ordClass,
  input  wire logic [7:0]           ordOpcode,
  input  wire logic [63:0]          ordAddr,
  input  wire logic                 ordFullLine,
  input  wire logic                 ordHasData,
  input  wire logic [3:0]           ordAttr,
  input  wire logic                 ordSecure,
  input  wire logic [3:0]           ordQos,
  input  wire logic [2:0]           ordBroadcast,
  input  wire logic [1:0]           ordReturnHint,
  input  wire logic [7:0]           ordAux,
  input  wire logic                 ordIdsValid,
  input  wire logic [5:0]           ordTgt,
  input  wire logic [5:0]           ordSrc,
  input  wire logic                 ordUserValid,
  input  wire logic [27:0]          ordUser,
  input  wire logic                 ordErrValid,
  input  wire logic [1:0]           ordRespErr,
  input  wire logic [7:0]           ordPoisonLow,
  input  wire logic [7:0]           ordPoisonHigh,
  output logic                      linkValid,
  input  wire logic                 linkReady,
  output logic [31:0]               linkData,
  output logic                      linkPktStart,
  output logic                      linkMsgLast,
  output logic                      linkPktEnd,
  output logic                      ordChained
);
  import mcx_pkg::*;

  if (EXT_SLOTS < 4 || EXT_SLOTS > EXT_LIMIT) begin : g_bad_slots
    $error("EXT_SLOTS must lie between 4 and 8");
  end

  typedef struct packed {
    mcx_state_t                   state;
    logic                         ordReady;
    logic                         linkValid;
    logic [31:0]                  linkData;
    logic                         pktStart;
    logic                         msgLast;
    logic                         pktEnd;
    logic                         chained;
    logic                         lastOfPkt;
    logic [WORD_SLOTS-1:0][31:0]  words;
    logic [3:0]                   count;
    logic [3:0]                   ptr;
    logic [5:0]                   pktTgt;
    logic [5:0]                   pktSrc;
    logic                         reqValid;
    logic [7:0]                   request_opcode;
    logic [3:0]                   request_attributes;
    logic                         reqSecure;
    logic [3:0]                   reqQos;
    logic [63:0]                  reqAddr;
    logic [5:0]                   reqTgt;
    logic [5:0]                   reqSrc;
    logic                         snpValid;
    logic [7:0]                   snoop_opcode;
    logic                         snpSecure;
    logic [63:0]                  snpAddr;
    logic [5:0]                   snpTgt;
    logic [5:0]                   snpSrc;
    logic [2:0]                   snoop_broadcast_field;
    logic [1:0]                   snpHint;
  } mcx_regs_t;

  mcx_regs_t st_q;
  mcx_regs_t st_d;

  logic        accept;
  logic        isReq;
  logic        isSnp;
  logic [5:0]  curPktTgt;
  logic [5:0]  curPktSrc;
  logic [5:0]  effTgt;
  logic [5:0]  effSrc;
  logic [63:0] lineBytes;
  logic [63:0] cleanAddr;
  logic        lineAligned;
  logic        request_chain_code;
  logic        snoop_chain_code;
  logic        uncachedOp;
  logic        wideAddr;
  logic        needIds;
  logic        needLow;
  logic        needUser;
  logic        needErr;

  // Drop address bits above the configured width
  function automatic logic [63:0] clip_addr(
    input logic [63:0] a,
    input mcx_awidth_t w
  );
    logic [63:0] m;
    m = 64'hFFFF_FFFF_FFFF_FFFF;
    case (w)
      AW_48:   m = 64'h0000_FFFF_FFFF_FFFF;
      AW_52:   m = 64'h000F_FFFF_FFFF_FFFF;
      AW_56:   m = 64'h00FF_FFFF_FFFF_FFFF;
      AW_60:   m = 64'h0FFF_FFFF_FFFF_FFFF;
      default: m = 64'hFFFF_FFFF_FFFF_FFFF;
    endcase
    return a & m;
  endfunction

  assign accept      = ordValid && st_q.ordReady;
  assign isReq       = (ordClass == MC_REQ);
  assign isSnp       = (ordClass == MC_SNP);
  assign curPktTgt   = ordFirst ? ordPktTgt : st_q.pktTgt;
  assign curPktSrc   = ordFirst ? ordPktSrc : st_q.pktSrc;
  assign effTgt      = ordIdsValid ? ordTgt : curPktTgt;
  assign effSrc      = ordIdsValid ? ordSrc : curPktSrc;
  assign lineBytes   = lineSize128 ? LINE_BYTES_128 : LINE_BYTES_64;
  assign cleanAddr   = clip_addr(ordAddr, addrWidthSetting);
  assign lineAligned = (cleanAddr[5:0] == 6'h00)
                       && (!lineSize128 || !cleanAddr[6]);
  assign uncachedOp  = (ordOpcode == OP_READ_UNCACHED)
                       || (ordOpcode == OP_WRITE_UNC_PART)
                       || (ordOpcode == OP_WRITE_COH_PART)
                       || ((ordOpcode >= OP_ATOMIC_FIRST)
                           && (ordOpcode <= OP_ATOMIC_LAST));
  assign wideAddr    = (addrWidthSetting == AW_56)
                       || (addrWidthSetting == AW_60)
                       || (addrWidthSetting == AW_64);

  // New packet breaks any chain; other classes leave chains alone
  assign request_chain_code = isReq && st_q.reqValid && !ordFirst
                    && ordFullLine && lineAligned
                    && (ordOpcode == st_q.request_opcode)
                    && (ordAttr == st_q.request_attributes)
                    && (ordSecure == st_q.reqSecure)
                    && (ordQos == st_q.reqQos)
                    && (effTgt == st_q.reqTgt)
                    && (effSrc == st_q.reqSrc)
                    && (cleanAddr == st_q.reqAddr + lineBytes);
  assign snoop_chain_code = isSnp && st_q.snpValid && !ordFirst
                    && ordFullLine && lineAligned
                    && (ordOpcode == st_q.snoop_opcode)
                    && (ordSecure == st_q.snpSecure)
                    && (ordBroadcast == st_q.snoop_broadcast_field)
                    && (ordReturnHint == st_q.snpHint)
                    && (effTgt == st_q.snpTgt)
                    && (effSrc == st_q.snpSrc)
                    && (cleanAddr == st_q.snpAddr + lineBytes);

  assign needIds  = ordIdsValid || ((isReq || isSnp)
                    && (wideAddr || cleanAddr[63:52] != 12'h000));
  assign needLow  = isReq && uncachedOp
                    && (cleanAddr[5:0] != 6'h00);
  assign needUser = ordUserValid && (ordClass != MC_MISC);
  assign needErr  = ordErrValid && ((isReq && ordHasData)
                    || (ordClass == MC_RSP));

  always_comb begin
    logic [3:0]  cur;
    logic [7:0]  hdrOp;
    logic [7:0]  hdrAux;
    logic [7:0]  ext0;
    logic [31:0] addrLoWord;
    logic [31:0] addrHiWord;
    logic        anyExt;
    cur        = 4'h0;
    hdrOp      = ordOpcode;
    hdrAux     = ordAux;
    ext0       = 8'h00;
    addrLoWord = cleanAddr[37:6];
    addrHiWord = 32'h0000_0000;
    anyExt     = needIds || needLow || needUser || needErr;
    st_d       = st_q;
    case (st_q.state)
      ST_IDLE: begin
        st_d.ordReady = 1'b1;
        if (accept) begin
          st_d.ordReady  = 1'b0;
          st_d.state     = ST_SEND;
          st_d.words     = '0;
          st_d.lastOfPkt = ordLast;
          st_d.chained   = request_chain_code || snoop_chain_code;
          if (ordFirst) begin
            st_d.pktTgt   = ordPktTgt;
            st_d.pktSrc   = ordPktSrc;
            st_d.reqValid = 1'b0;
            st_d.snpValid = 1'b0;
          end
          if (request_chain_code) begin
            hdrOp = REQ_CHAIN_CODE;
          end else if (snoop_chain_code) begin
            hdrOp = SNP_CHAIN_CODE;
          end
          if (isSnp) begin
            hdrAux = snoop_chain_code ? {st_q.snoop_broadcast_field, st_q.snpHint, 3'h0}
                              : {ordBroadcast, ordReturnHint, 3'h0};
          end
          // Header word, class and extension flag in byte 0
          st_d.words[cur] = {8'h00, hdrAux, hdrOp,
                             anyExt, 1'b0, ordClass, 4'h0};
          cur = cur + CNT_ONE;
          // Extensions right after the header, kinds rising
          if (needIds) begin
            ext0 = 8'h00;
            ext0[EXT_MORE_BIT] = needLow || needUser || needErr;
            ext0[EXT_KIND_LSB +: 3] = KIND_IDS;
            st_d.words[cur] = (isReq || isSnp)
              ? {cleanAddr[59:52], effTgt[1:0], effSrc,
                 cleanAddr[63:60], effTgt[5:2], ext0}
              : {8'h00, effTgt[1:0], effSrc,
                 4'h0, effTgt[5:2], ext0};
            cur = cur + CNT_ONE;
          end
          if (needLow) begin
            ext0 = 8'h00;
            ext0[EXT_MORE_BIT] = needUser || needErr;
            ext0[EXT_KIND_LSB +: 3] = KIND_LOWADDR;
            st_d.words[cur] = {2'h0, cleanAddr[5:0], 16'h0000,
                               ext0};
            cur = cur + CNT_ONE;
          end
          if (needUser) begin
            ext0 = 8'h00;
            ext0[EXT_MORE_BIT] = needErr;
            ext0[EXT_KIND_LSB +: 3] = KIND_USER;
            ext0[3:0] = ordUser[27:24];
            st_d.words[cur] = {ordUser[7:0], ordUser[15:8],
                               ordUser[23:16], ext0};
            cur = cur + CNT_ONE;
          end
          if (needErr) begin
            ext0 = 8'h00;
            ext0[EXT_KIND_LSB +: 3] = KIND_ERR;
            ext0[1:0] = ordRespErr;
            st_d.words[cur] = {ordPoisonHigh, ordPoisonLow, 8'h00,
                               ext0};
            cur = cur + CNT_ONE;
          end
          // Address words only for unchained Requests and Snoops
          if ((isReq && !request_chain_code) || (isSnp && !snoop_chain_code)) begin
            addrHiWord = {ordSecure, (isReq ? ordQos : 4'h0),
                          (isReq ? ordAttr : 4'h0), 9'h000,
                          cleanAddr[51:38]};
            st_d.words[cur] = addrLoWord;
            cur = cur + CNT_ONE;
            st_d.words[cur] = addrHiWord;
            cur = cur + CNT_ONE;
          end
          st_d.count     = cur;
          st_d.ptr       = CNT_ONE;
          st_d.linkValid = 1'b1;
          st_d.linkData  = st_d.words[0];
          st_d.pktStart  = ordFirst;
          st_d.msgLast   = (cur == CNT_ONE);
          st_d.pktEnd    = ordLast && (cur == CNT_ONE);
          // Chain bookkeeping; other classes touch it only at a packet start or end
          if (isReq) begin
            st_d.reqValid = 1'b1;
            st_d.reqAddr  = cleanAddr;
            if (!request_chain_code) begin
              st_d.request_opcode     = ordOpcode;
              st_d.request_attributes   = ordAttr;
              st_d.reqSecure = ordSecure;
              st_d.reqQos    = ordQos;
              st_d.reqTgt    = effTgt;
              st_d.reqSrc    = effSrc;
            end
          end
          if (isSnp) begin
            st_d.snpValid = 1'b1;
            st_d.snpAddr  = cleanAddr;
            if (!snoop_chain_code) begin
              st_d.snoop_opcode     = ordOpcode;
              st_d.snpSecure = ordSecure;
              st_d.snpTgt    = effTgt;
              st_d.snpSrc    = effSrc;
              st_d.snoop_broadcast_field   = ordBroadcast;
              st_d.snpHint   = ordReturnHint;
            end
          end
          if (ordLast) begin
            st_d.reqValid = 1'b0;
            st_d.snpValid = 1'b0;
          end
        end
      end
      ST_SEND: begin
        if (linkReady) begin
          if (st_q.ptr == st_q.count) begin
            st_d.state     = ST_IDLE;
            st_d.ordReady  = 1'b1;
            st_d.linkValid = 1'b0;
            st_d.pktStart  = 1'b0;
            st_d.msgLast   = 1'b0;
            st_d.pktEnd    = 1'b0;
          end else begin
            st_d.linkData = st_q.words[st_q.ptr];
            st_d.ptr      = st_q.ptr + CNT_ONE;
            st_d.pktStart = 1'b0;
            st_d.msgLast  = (st_q.ptr + CNT_ONE == st_q.count);
            st_d.pktEnd   = st_q.lastOfPkt
                            && (st_q.ptr + CNT_ONE == st_q.count);
          end
        end
      end
      default: begin
        st_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ordReady     = st_q.ordReady;
  assign linkValid    = st_q.linkValid;
  assign linkData     = st_q.linkData;
  assign linkPktStart = st_q.pktStart;
  assign linkMsgLast  = st_q.msgLast;
  assign linkPktEnd   = st_q.pktEnd;
  assign ordChained   = st_q.chained;

endmodule

// ===== tb/mcx_packer_monitor.sv
// Concurrent checks on the packer's order and link ports.
// Assumes it is bound into mcx_packer and sees only its ports.
`timescale 1ns/100ps
module mcx_packer_monitor #(
  parameter int EXT_SLOTS = mcx_pkg::EXT_LIMIT
) (
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  input wire mcx_pkg::mcx_awidth_t addrWidthSetting,
  input wire logic                 ordValid,
  input wire logic                 ordReady,
  input wire logic                 ordFirst,
  input wire mcx_pkg::mcx_class_t  ordClass,
  input wire logic [63:0]          ordAddr,
  input wire logic                 ordFullLine,
  input wire logic                 ordIdsValid,
  input wire logic                 ordUserValid,
  input wire logic                 ordErrValid,
  input wire logic                 linkValid,
  input wire logic                 linkReady,
  input wire logic [31:0]          linkData,
  input wire logic                 linkPktStart,
  input wire logic                 linkMsgLast,
  input wire logic                 linkPktEnd,
  input wire logic                 ordChained
);
  import mcx_pkg::*;
  logic take;
  logic bare;
  assign take = ordValid && ordReady;
  // No extension can appear, so a chained Request is header only
  assign bare = !ordIdsValid && !ordUserValid && !ordErrValid
                && ordAddr[63:52] == 12'h000 && addrWidthSetting < AW_56;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_hdr_class: assert property (take |=> linkValid && !ordReady
    && linkData[5:4] == $past(ordClass)) else $error("header class wrong");
  chk_ext_flag: assert property (take && (ordIdsValid
    || (ordUserValid && ordClass != MC_MISC)) |=> linkData[HDR_EXT_BIT])
    else $error("extension flag missing");
  chk_req_chain: assert property (take && ordClass == MC_REQ ##1
    ordChained |-> linkData[15:8] == REQ_CHAIN_CODE)
    else $error("chained request opcode wrong");
  chk_snp_chain: assert property (take && ordClass == MC_SNP ##1
    ordChained |-> linkData[15:8] == SNP_CHAIN_CODE)
    else $error("chained snoop opcode wrong");
  chk_chain_short: assert property (take && ordClass == MC_REQ && bare
    ##1 ordChained |-> linkMsgLast) else $error("chained request too long");
  chk_chain_full: assert property (take && !ordFullLine |=>
    !ordChained) else $error("partial access chained");
  chk_chain_packet: assert property (take && ordFirst |=>
    !ordChained && linkPktStart) else $error("chain crossed packet");
  chk_word_stands: assert property (linkValid && !linkReady |=>
    linkValid && $stable(linkData) && $stable(linkMsgLast))
    else $error("link word changed while stalled");
  chk_wide_ids: assert property (take && ordClass != MC_RSP
    && ordClass != MC_MISC && addrWidthSetting >= AW_56
    |=> linkData[HDR_EXT_BIT]) else $error("wide address without ids");
  chk_end_last: assert property (linkPktEnd |-> linkValid && linkMsgLast)
    else $error("packet end off a message end");
  chk_ready_back: assert property (linkValid && linkReady && linkMsgLast
    |=> !linkValid ##1 ordReady) else $error("order port not reopened");

  cov_req_chain: cover property (take && ordClass == MC_REQ ##1 ordChained);
  cov_snp_chain: cover property (take && ordClass == MC_SNP ##1 ordChained);
  cov_stall: cover property (linkValid && !linkReady);
endmodule

// ===== tb/mcx_link_sink.sv
// Peer protocol layer: takes link words, stalls every other cycle
// when slow is set. Assumes one clock shared with the packer.
`timescale 1ns/100ps
module mcx_link_sink (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        slow,
  input wire logic        linkValid,
  input wire logic [31:0] linkData,
  input wire logic        linkMsgLast,
  input wire logic        linkPktEnd,
  output logic            linkReady
);
  logic [31:0] got[$];
  int          msgs;
  int          pkts;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      linkReady <= 1'h0;
      msgs <= 0;
      pkts <= 0;
    end else begin
      linkReady <= slow ? !linkReady : 1'h1;
      if (linkValid && linkReady) begin
        // Raw words kept, unknown kinds pass without complaint
        got.push_back(linkData);
        if (linkMsgLast)
          msgs <= msgs + 1;
        if (linkPktEnd)
          pkts <= pkts + 1;
      end
    end
  end
endmodule

// ===== tb/mcx_packer_bench.sv
// Self-checking bench for mcx_packer with the link sink model.
// Assumes 100 MHz sys_clk and synchronous active-low reset.
`timescale 1ns/100ps
module mcx_packer_bench;
  import mcx_pkg::*;
  logic        sys_clk = 1'h0, rst_n = 1'h0, lineSize128 = 1'h0;
  logic        slow = 1'h0, ordValid = 1'h0, ordFirst = 1'h0;
  logic        ordLast = 1'h0, ordFullLine = 1'h0, ordHasData = 1'h0;
  logic        ordSecure = 1'h0, ordIdsValid = 1'h0, ordUserValid = 1'h0;
  logic        ordErrValid = 1'h0;
  logic [1:0]  ordReturnHint = 2'h0, ordRespErr = 2'h0;
  logic [2:0]  ordBroadcast = 3'h0;
  logic [3:0]  ordAttr = 4'h0, ordQos = 4'h0;
  logic [5:0]  ordPktTgt = 6'h00, ordPktSrc = 6'h00;
  logic [5:0]  ordTgt = 6'h00, ordSrc = 6'h00;
  logic [7:0]  ordOpcode = 8'h00, ordAux = 8'h00;
  logic [7:0]  ordPoisonLow = 8'h00, ordPoisonHigh = 8'h00;
  logic [27:0] ordUser = 28'h0;
  logic [63:0] ordAddr = 64'h0;
  mcx_class_t  ordClass = MC_REQ;
  mcx_awidth_t addrWidthSetting = AW_48;
  logic        ordReady, linkValid, linkReady, linkPktStart;
  logic        linkMsgLast, linkPktEnd, ordChained;
  logic [31:0] linkData;
  logic [31:0] exp[$];
  int          mismatches = 0;
  int          cmp_count = 0;

  always #5 sys_clk = ~sys_clk;

  mcx_packer DUT (.sys_clk, .rst_n, .lineSize128, .addrWidthSetting,
    .ordValid, .ordReady, .ordFirst, .ordLast, .ordPktTgt, .ordPktSrc,
    .ordClass, .ordOpcode, .ordAddr, .ordFullLine, .ordHasData, .ordAttr,
    .ordSecure, .ordQos, .ordBroadcast, .ordReturnHint, .ordAux,
    .ordIdsValid, .ordTgt, .ordSrc, .ordUserValid, .ordUser, .ordErrValid,
    .ordRespErr, .ordPoisonLow, .ordPoisonHigh, .linkValid, .linkReady,
    .linkData, .linkPktStart, .linkMsgLast, .linkPktEnd, .ordChained);
  mcx_link_sink sink (.sys_clk, .rst_n, .slow, .linkValid, .linkData,
    .linkMsgLast, .linkPktEnd, .linkReady);

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_msg();
    cmp("word count", 32'(exp.size()), 32'(sink.got.size()));
    foreach (exp[i])
      cmp("link word", exp[i], sink.got[i]);
    exp.delete();
  endtask

  function automatic logic [31:0] hdr(input logic e, input mcx_class_t c,
                                      input logic [7:0] op, b2);
    return {8'h00, b2, op, e, 1'h0, c, 4'h0};
  endfunction

  task automatic addr_words(input logic [63:0] a, input logic s,
                            input logic [3:0] q, t);
    exp.push_back(a[37:6]);
    exp.push_back({s, q, t, 9'h000, a[51:38]});
  endtask

  // One message through the order port; waits for it to drain
  task automatic order(input mcx_class_t c, input logic [7:0] op,
                       input logic [63:0] a, input logic f, l, full);
    int n;
    sink.got.delete();
    @(posedge sys_clk);
    ordClass <= c;
    ordOpcode <= op;
    ordAddr <= a;
    ordFirst <= f;
    ordLast <= l;
    ordFullLine <= full;
    ordValid <= 1'h1;
    @(negedge sys_clk);
    for (n = 0; n < 50 && !ordReady; n++)
      @(negedge sys_clk);
    @(posedge sys_clk);
    ordValid <= 1'h0;
    @(negedge sys_clk);
    for (n = 0; n < 200 && !ordReady; n++)
      @(negedge sys_clk);
    if (!ordReady) begin
      mismatches++;
      $display("[ERR] order port expected ready seen busy");
      test_done();
    end
  endtask

  task automatic req_chain();
    @(posedge sys_clk);
    ordPktTgt <= 6'h11;
    ordPktSrc <= 6'h22;
    ordAttr <= 4'h3;
    ordSecure <= 1'h1;
    ordQos <= 4'hA;
    order(MC_REQ, 8'h05, 64'h1000, 1'h1, 1'h0, 1'h1);
    exp.push_back(hdr(1'h0, MC_REQ, 8'h05, 8'h00));
    addr_words(64'h1000, 1'h1, 4'hA, 4'h3);
    cmp_msg();
    order(MC_RSP, 8'h02, 64'h0, 1'h0, 1'h0, 1'h0);
    exp.push_back(hdr(1'h0, MC_RSP, 8'h02, 8'h00));
    cmp_msg();
    order(MC_REQ, 8'h05, 64'h1040, 1'h0, 1'h1, 1'h1);
    exp.push_back(hdr(1'h0, MC_REQ, REQ_CHAIN_CODE, 8'h00));
    cmp_msg();
    cmp("chained", 32'h1, {31'h0, ordChained});
    order(MC_REQ, 8'h05, 64'h1080, 1'h1, 1'h1, 1'h1);
    exp.push_back(hdr(1'h0, MC_REQ, 8'h05, 8'h00));
    addr_words(64'h1080, 1'h1, 4'hA, 4'h3);
    cmp_msg();
  endtask

  task automatic snp_chain();
    @(posedge sys_clk);
    lineSize128 <= 1'h1;
    ordBroadcast <= 3'h5;
    ordReturnHint <= 2'h2;
    ordSecure <= 1'h0;
    order(MC_SNP, 8'h07, 64'h2000, 1'h1, 1'h0, 1'h1);
    exp.push_back(hdr(1'h0, MC_SNP, 8'h07, {3'h5, 2'h2, 3'h0}));
    addr_words(64'h2000, 1'h0, 4'h0, 4'h0);
    cmp_msg();
    order(MC_SNP, 8'h07, 64'h2080, 1'h0, 1'h1, 1'h1);
    exp.push_back(hdr(1'h0, MC_SNP, SNP_CHAIN_CODE, {3'h5, 2'h2, 3'h0}));
    cmp_msg();
    cmp("chained", 32'h1, {31'h0, ordChained});
  endtask

  // Slow sink here so every extension word sees a stall
  task automatic ext_words();
    @(posedge sys_clk);
    lineSize128 <= 1'h0;
    slow <= 1'h1;
    {ordIdsValid, ordUserValid, ordErrValid} <= 3'h7;
    ordTgt <= 6'h2D;
    ordSrc <= 6'h13;
    ordUser <= 28'hABCDEF1;
    ordRespErr <= 2'h2;
    ordPoisonLow <= 8'h5A;
    ordPoisonHigh <= 8'hC3;
    order(MC_RSP, 8'h04, 64'h0, 1'h1, 1'h1, 1'h0);
    exp = '{hdr(1'h1, MC_RSP, 8'h04, 8'h00), 32'h00530B80,
            32'hF1DEBCAA, 32'hC35A0062};
    cmp_msg();
    @(posedge sys_clk);
    ordIdsValid <= 1'h0;
    order(MC_MISC, 8'h01, 64'h0, 1'h1, 1'h1, 1'h0);
    exp.push_back(hdr(1'h0, MC_MISC, 8'h01, 8'h00));
    cmp_msg();
    @(posedge sys_clk);
    slow <= 1'h0;
    {ordUserValid, ordErrValid} <= 2'h0;
  endtask

  task automatic low_addr();
    logic [7:0] ops [4];
    ops = '{OP_READ_UNCACHED, OP_WRITE_UNC_PART, OP_WRITE_COH_PART,
            OP_ATOMIC_LAST};
    @(posedge sys_clk);
    ordAttr <= 4'h0;
    ordQos <= 4'h0;
    foreach (ops[i]) begin
      order(MC_REQ, ops[i], 64'h3025, 1'h1, 1'h1, 1'h0);
      exp = '{hdr(1'h1, MC_REQ, ops[i], 8'h00), 32'h25000010};
      addr_words(64'h3025, 1'h0, 4'h0, 4'h0);
      cmp_msg();
    end
    order(MC_REQ, 8'h05, 64'h3025, 1'h1, 1'h1, 1'h0);
    exp.push_back(hdr(1'h0, MC_REQ, 8'h05, 8'h00));
    addr_words(64'h3025, 1'h0, 4'h0, 4'h0);
    cmp_msg();
  endtask

  task automatic wide_addr();
    @(posedge sys_clk);
    addrWidthSetting <= AW_64;
    order(MC_REQ, 8'h05, 64'hA5B0_0000_0000_1000, 1'h1, 1'h1, 1'h1);
    exp = '{hdr(1'h1, MC_REQ, 8'h05, 8'h00), 32'h5B62A400};
    addr_words(64'hA5B0_0000_0000_1000, 1'h0, 4'h0, 4'h0);
    cmp_msg();
    @(posedge sys_clk);
    addrWidthSetting <= AW_48;
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'h1;
    req_chain();
    snp_chain();
    ext_words();
    low_addr();
    wide_addr();
    cmp("messages", 32'h0E, 32'(sink.msgs));
    cmp("packets", 32'h0B, 32'(sink.pkts));
    test_done();
  end
endmodule

bind mcx_packer mcx_packer_monitor #(.EXT_SLOTS(EXT_SLOTS)) mon (
  .sys_clk, .rst_n, .addrWidthSetting, .ordValid, .ordReady, .ordFirst,
  .ordClass, .ordAddr, .ordFullLine, .ordIdsValid, .ordUserValid,
  .ordErrValid, .linkValid, .linkReady, .linkData, .linkPktStart,
  .linkMsgLast, .linkPktEnd, .ordChained);
